// ### hw/ies_consts.vh
/*
 Constants for the common-command status block: command codes,
 event status bit positions, masks and reset values.
 Assumes it is included by bare name from the design module.
*/
`ifndef IES_CONSTS_VH
`define IES_CONSTS_VH

// Common command codes on i_cmd_code
`define IES_CMD_CLS       4'h0
`define IES_CMD_MASK_SET  4'h1
`define IES_CMD_MASK_Q    4'h2
`define IES_CMD_STATUS_Q  4'h3
`define IES_CMD_IDN_Q     4'h4
`define IES_CMD_OPC       4'h5
`define IES_CMD_OPC_Q     4'h6
`define IES_CMD_OPT_Q     4'h7

// Error classes on i_err_class
`define IES_ERR_CMD       3'h1
`define IES_ERR_EXE       3'h2
`define IES_ERR_DEV       3'h3
`define IES_ERR_QRY       3'h4

// Event status / enable bit positions
`define IES_BIT_OPC       0
`define IES_BIT_QYE       2
`define IES_BIT_DDE       3
`define IES_BIT_EXE       4
`define IES_BIT_CME       5
`define IES_STATUS_USED   8'h3D

// Status byte bit positions
`define IES_STB_ESB       5
`define IES_STB_MSS       6

// Reset values and argument range
`define IES_MASK_RST      8'h00
`define IES_STATUS_RST    8'h00
`define IES_ARG_MAX       16'h00FF

// Response sources
`define IES_SRC_NUM       2'h0
`define IES_SRC_IDN       2'h1
`define IES_SRC_OPT       2'h2

`define IES_ASCII_0       8'h30
`define IES_ASCII_1       8'h31

`endif

// ### hw/ies_event_status.v
/*
 Common-command status logic: event status register and enable mask,
 event summary and master summary bits of the status byte, clear-status,
 error-class mapping, operation-complete tracking and the identification
 and options strings, answered one ASCII byte at a time.
 Assumes a parser upstream hands over decoded common commands, and that
 error reports, processor idle flags and the other status byte bits come
 from logic on the same clock.
*/
`timescale 1ns/1ns
`include "ies_consts.vh"

// Contract
// - Clear-status empties error queue, idles completion
// - Clear-status clears event registers, keeps masks
// - Enable mask takes 0..255, resets zero
// - Summary bit 5 is OR of enabled events
// - Bits 5,4,3,2,0 are CME,EXE,DDE,QYE,OPC
// - Enable query returns mask unchanged
// - Status query returns then clears register
// - Class 100 errors set bit 5
// - Class 200 errors set bit 4
// - Class 300 or level error sets bit 3; the code sets it for a level error only with i_ques_level
// - Class 400 errors set bit 2
// - Identity string has four comma fields
// - Date MM/DD/YYYY, serial exactly six digits
// - Completion command clears bit 0, set later
// - Complete only when three processors idle
// - Commands keep flowing while bit 0 zero
// - Completion query answers ASCII 0 or 1
// - Options string lists four capability tokens
// - Common commands need leading asterisk
// - Bit 6 is OR of enabled status bits
module ies_event_status #(
    parameter IDN_LEN = 42,
    parameter [8*IDN_LEN-1:0] IDN_STR =
        "MAKER,PSU0000 36-28 01/01/2000,000001,1.00",
    parameter OPT_LEN = 27,
    parameter [8*OPT_LEN-1:0] OPT_STR = "LIMCAL,REMBUS,MEMLOC,LISTAP"
) (
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_cmd_valid,
    input  wire        i_cmd_star,
    input  wire [3:0]  i_cmd_code,
    input  wire [15:0] i_cmd_arg,
    input  wire        i_err_valid,
    input  wire [2:0]  i_err_class,
    input  wire        i_level_err,
    input  wire        i_ques_level,
    input  wire [2:0]  i_proc_idle,
    input  wire [7:0]  i_stb_ext,
    input  wire [7:0]  i_sre,
    input  wire        i_resp_ready,
    output wire [7:0]  o_event_enable_mask,
    output wire [7:0]  o_standard_event_status,
    output wire [7:0]  o_stb,
    output wire        o_cls,
    output wire        o_resp_valid,
    output wire [7:0]  o_resp_byte,
    output wire        o_resp_last
);

////////////////////////////////////////////////////////////////////////////////
// Storage

reg  [7:0]  event_enable_mask_r;
reg  [7:0]  event_enable_mask_nxt;
reg  [7:0]  standard_event_status_r;
reg  [7:0]  standard_event_status_nxt;
reg         pend_r;
reg         pend_nxt;
reg  [7:0]  stb_r;
reg  [7:0]  stb_nxt;
reg         cls_r;
reg         cls_nxt;
reg         rv_r;
reg         rv_nxt;
reg  [7:0]  rb_r;
reg  [7:0]  rb_nxt;
reg         rl_r;
reg         rl_nxt;
reg  [1:0]  src_r;
reg  [1:0]  src_nxt;
reg  [5:0]  idx_r;
reg  [5:0]  idx_nxt;
reg  [5:0]  len_r;
reg  [5:0]  len_nxt;
reg  [23:0] num_r;
reg  [23:0] num_nxt;

////////////////////////////////////////////////////////////////////////////////
// Decoding helpers

// Up to three ASCII digits, most significant first, no leading zeros
function [23:0] to_dec;
    input [7:0] v;
    reg   [7:0] h;
    reg   [7:0] t;
    reg   [7:0] u;
    begin
        h = v / 8'd100;
        t = (v % 8'd100) / 8'd10;
        u = v % 8'd10;
        if (v >= 8'd100)
            to_dec = {`IES_ASCII_0 + h, `IES_ASCII_0 + t, `IES_ASCII_0 + u};
        else if (v >= 8'd10)
            to_dec = {`IES_ASCII_0 + t, `IES_ASCII_0 + u, 8'h00};
        else
            to_dec = {`IES_ASCII_0 + u, 16'h0000};
    end
endfunction

function [5:0] dec_len;
    input [7:0] v;
    begin
        if (v >= 8'd100)
            dec_len = 6'd3;
        else if (v >= 8'd10)
            dec_len = 6'd2;
        else
            dec_len = 6'd1;
    end
endfunction

function [7:0] get_byte;
    input [1:0]  src;
    input [5:0]  idx;
    input [23:0] num;
    begin
        case (src)
            `IES_SRC_IDN:
                get_byte = IDN_STR[8*(IDN_LEN-1-idx) +: 8];
            `IES_SRC_OPT:
                get_byte = OPT_STR[8*(OPT_LEN-1-idx) +: 8];
            default:
                get_byte = num[8*(2-idx[1:0]) +: 8];
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Command, event and response logic

reg        take;
reg        is_query;
reg        q_ok;
reg  [7:0] set_v;
reg  [7:0] clr_v;
reg  [7:0] ans;
reg        esb;
reg        done;
reg        adv;

always @*
begin
    event_enable_mask_nxt = event_enable_mask_r;
    pend_nxt = pend_r;
    cls_nxt  = 1'b0;
    rv_nxt   = rv_r;
    rb_nxt   = rb_r;
    rl_nxt   = rl_r;
    src_nxt  = src_r;
    idx_nxt  = idx_r;
    len_nxt  = len_r;
    num_nxt  = num_r;
    set_v    = 8'h00;
    clr_v    = 8'h00;
    ans      = 8'h00;

    // A command without the leading asterisk is not a common command
    take     = i_cmd_valid & i_cmd_star;
    if (i_cmd_valid & ~i_cmd_star)
        set_v[`IES_BIT_CME] = 1'b1;

    is_query = (i_cmd_code == `IES_CMD_MASK_Q) | (i_cmd_code == `IES_CMD_STATUS_Q) |
               (i_cmd_code == `IES_CMD_IDN_Q) | (i_cmd_code == `IES_CMD_OPC_Q) |
               (i_cmd_code == `IES_CMD_OPT_Q);
    // A query arriving while an answer drains is dropped and flagged
    q_ok     = take & is_query & ~rv_r;
    if (take & is_query & rv_r)
        set_v[`IES_BIT_QYE] = 1'b1;

    // Error classes map onto event bits
    if (i_err_valid)
    begin
        case (i_err_class)
            `IES_ERR_CMD: set_v[`IES_BIT_CME] = 1'b1;
            `IES_ERR_EXE: set_v[`IES_BIT_EXE] = 1'b1;
            `IES_ERR_DEV: set_v[`IES_BIT_DDE] = 1'b1;
            `IES_ERR_QRY: set_v[`IES_BIT_QYE] = 1'b1;
            default:      set_v = set_v;
        endcase
    end
    if (i_level_err & i_ques_level)
        set_v[`IES_BIT_DDE] = 1'b1;

    // Completion waits for all three processors; commands are never held
    done = pend_r & (&i_proc_idle);
    if (done)
    begin
        set_v[`IES_BIT_OPC] = 1'b1;
        pend_nxt = 1'b0;
    end

    if (take)
    begin
        case (i_cmd_code)
            `IES_CMD_CLS:
            begin
                clr_v    = 8'hFF;
                pend_nxt = 1'b0;
                cls_nxt  = 1'b1;
            end
            `IES_CMD_MASK_SET:
            begin
                if (i_cmd_arg <= `IES_ARG_MAX)
                    event_enable_mask_nxt = i_cmd_arg[7:0] & `IES_STATUS_USED;
                else
                    set_v[`IES_BIT_EXE] = 1'b1;
            end
            `IES_CMD_OPC:
                pend_nxt = 1'b1;
            `IES_CMD_MASK_Q:
                ans = event_enable_mask_r;
            `IES_CMD_STATUS_Q:
            begin
                ans = standard_event_status_r;
                if (q_ok)
                    clr_v = standard_event_status_r;
            end
            default:
                ans = 8'h00;
        endcase
    end

    // Hardware sets win over the read-clear and clear-status
    standard_event_status_nxt = ((standard_event_status_r & ~clr_v) | set_v)
                                & `IES_STATUS_USED;
    if (take & (i_cmd_code == `IES_CMD_OPC))
        standard_event_status_nxt[`IES_BIT_OPC] = 1'b0;

    // Start an answer
    if (q_ok)
    begin
        rv_nxt  = 1'b1;
        idx_nxt = 6'd0;
        case (i_cmd_code)
            `IES_CMD_IDN_Q:
            begin
                src_nxt = `IES_SRC_IDN;
                len_nxt = IDN_LEN[5:0];
            end
            `IES_CMD_OPT_Q:
            begin
                src_nxt = `IES_SRC_OPT;
                len_nxt = OPT_LEN[5:0];
            end
            `IES_CMD_OPC_Q:
            begin
                src_nxt = `IES_SRC_NUM;
                len_nxt = 6'd1;
                num_nxt = {(pend_r ? `IES_ASCII_0 : `IES_ASCII_1), 16'h0000};
            end
            default:
            begin
                src_nxt = `IES_SRC_NUM;
                len_nxt = dec_len(ans);
                num_nxt = to_dec(ans);
            end
        endcase
        rb_nxt = get_byte(src_nxt, 6'd0, num_nxt);
        rl_nxt = (len_nxt == 6'd1);
    end

    // Stream the answer one byte per accepted handshake
    adv = rv_r & i_resp_ready;
    if (adv)
    begin
        if (rl_r)
        begin
            rv_nxt = 1'b0;
            rl_nxt = 1'b0;
        end
        else
        begin
            idx_nxt = idx_r + 6'd1;
            rb_nxt  = get_byte(src_r, idx_nxt, num_r);
            rl_nxt  = (idx_nxt == len_r - 6'd1);
        end
    end

    // Status byte summaries; clear-status drops the event summary
    esb = |(standard_event_status_r & event_enable_mask_r & `IES_STATUS_USED)
          & ~cls_nxt;
    stb_nxt = i_stb_ext;
    stb_nxt[`IES_STB_ESB] = esb;
    stb_nxt[`IES_STB_MSS] = 1'b0;
    // Bit 6 cannot enable itself
    stb_nxt[`IES_STB_MSS] = |(stb_nxt & i_sre & ~8'h40);
end

////////////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge i_clk)
begin
    if (!i_nrst)
    begin
        event_enable_mask_r     <= `IES_MASK_RST;
        standard_event_status_r <= `IES_STATUS_RST;
        pend_r <= 1'b0;
        stb_r  <= 8'h00;
        cls_r  <= 1'b0;
        rv_r   <= 1'b0;
        rb_r   <= 8'h00;
        rl_r   <= 1'b0;
        src_r  <= `IES_SRC_NUM;
        idx_r  <= 6'd0;
        len_r  <= 6'd0;
        num_r  <= 24'h000000;
    end
    else
    begin
        event_enable_mask_r     <= event_enable_mask_nxt;
        standard_event_status_r <= standard_event_status_nxt;
        pend_r <= pend_nxt;
        stb_r  <= stb_nxt;
        cls_r  <= cls_nxt;
        rv_r   <= rv_nxt;
        rb_r   <= rb_nxt;
        rl_r   <= rl_nxt;
        src_r  <= src_nxt;
        idx_r  <= idx_nxt;
        len_r  <= len_nxt;
        num_r  <= num_nxt;
    end
end

assign o_event_enable_mask     = event_enable_mask_r;
assign o_standard_event_status = standard_event_status_r;
assign o_stb        = stb_r;
assign o_cls        = cls_r;
assign o_resp_valid = rv_r;
assign o_resp_byte  = rb_r;
assign o_resp_last  = rl_r;

endmodule // ies_event_status

// ### dv/ies_event_status_assertions.sv
/* Checker for the event status block.
   Assumes a bind onto ies_event_status with one clock. */
`timescale 1ns/1ns
`include "ies_consts.vh"
module ies_event_status_assertions (
    input wire        i_clk,
    input wire        i_nrst,
    input wire        i_cmd_valid,
    input wire        i_cmd_star,
    input wire [3:0]  i_cmd_code,
    input wire [15:0] i_cmd_arg,
    input wire        i_err_valid,
    input wire [2:0]  i_err_class,
    input wire [7:0]  o_event_enable_mask,
    input wire [7:0]  o_standard_event_status,
    input wire [7:0]  o_stb,
    input wire        o_cls,
    input wire        o_resp_valid
);
    wire       tk  = i_cmd_valid && i_cmd_star;
    wire [7:0] msk = o_event_enable_mask;
    wire [7:0] st  = o_standard_event_status;
    wire       qry = i_cmd_code == `IES_CMD_MASK_Q || i_cmd_code == `IES_CMD_STATUS_Q ||
                     i_cmd_code == `IES_CMD_IDN_Q || i_cmd_code == `IES_CMD_OPC_Q ||
                     i_cmd_code == `IES_CMD_OPT_Q;
    reg        clr_r;
    // Only these commands may lower an event bit
    always @(posedge i_clk)
        clr_r <= tk && (i_cmd_code == `IES_CMD_CLS || i_cmd_code == `IES_CMD_STATUS_Q ||
                        i_cmd_code == `IES_CMD_OPC);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_cls_pulse: assert property (tk && i_cmd_code == `IES_CMD_CLS |=> o_cls)
        else $error("clear pulse missing");
    a_cls_clears: assert property (tk && i_cmd_code == `IES_CMD_CLS && !i_err_valid
        |=> (st & 8'h3C) == 8'h00 && $stable(msk)) else $error("clear wrong");
    a_mask_write: assert property (tk && i_cmd_code == `IES_CMD_MASK_SET
        && i_cmd_arg <= 16'h00FF |=> msk == ($past(i_cmd_arg[7:0]) & 8'h3D))
        else $error("mask write wrong");
    a_mask_range: assert property (tk && i_cmd_code == `IES_CMD_MASK_SET
        && i_cmd_arg > 16'h00FF |=> $stable(msk) && st[4]) else $error("range refusal wrong");
    // Clear-status masks the summary bit directly, so the summary drops for that cycle
    a_esb_sum: assert property (o_stb[5] == (|($past(st) & $past(msk))
        && !$past(tk && i_cmd_code == `IES_CMD_CLS))) else $error("summary bit wrong");
    a_unused_zero: assert property (((st | msk) & 8'hC2) == 8'h00)
        else $error("unused bit set");
    a_err_map: assert property (i_err_valid && i_err_class inside {[1:4]}
        |=> st[3'd6 - $past(i_err_class)]) else $error("error class bit missing");
    a_no_star: assert property (i_cmd_valid && !i_cmd_star |=> st[5])
        else $error("missing star not flagged");
    a_read_clear: assert property (tk && i_cmd_code == `IES_CMD_STATUS_Q
        && !o_resp_valid && !i_err_valid |=> (st & 8'h3C) == 8'h00)
        else $error("read clear missing");
    a_busy_query: assert property (tk && qry && o_resp_valid |=> st[2])
        else $error("busy query not flagged");
    a_bit_latch: assert property (|($past(st) & ~st) |-> clr_r)
        else $error("event bit dropped");
    a_opc_clear: assert property (tk && i_cmd_code == `IES_CMD_OPC |=> !st[0])
        else $error("completion bit not cleared");
    c_status_q: cover property (tk && i_cmd_code == `IES_CMD_STATUS_Q);
    c_opc: cover property (tk && i_cmd_code == `IES_CMD_OPC ##[1:20] st[0]);
    c_cls: cover property (o_cls);
    c_busy: cover property (tk && qry && o_resp_valid);
endmodule // ies_event_status_assertions
bind ies_event_status ies_event_status_assertions u_chk (.i_clk, .i_nrst, .i_cmd_valid,
    .i_cmd_star, .i_cmd_code, .i_cmd_arg, .i_err_valid, .i_err_class, .o_event_enable_mask,
    .o_standard_event_status, .o_stb, .o_cls, .o_resp_valid);

// ### dv/ies_resp_sink.sv
/* Controller-side consumer of answer bytes.
   Assumes answers arrive as valid/ready bytes on the same clock. */
`timescale 1ns/1ns
module ies_resp_sink (
    input wire        i_clk,
    input wire        i_valid,
    input wire [7:0]  i_byte,
    input wire        i_last,
    input wire        i_slow,
    output wire       o_ready
);
    logic [7:0] q[$];
    logic       done = 1'b0;
    logic       ph = 1'b0;
    // Slow mode stalls every other cycle to test byte holding
    assign o_ready = !i_slow | ph;
    always @(posedge i_clk)
    begin
        ph <= ~ph;
        if (i_valid && o_ready)
        begin
            q.push_back(i_byte);
            if (i_last)
                done <= 1'b1;
        end
    end
endmodule // ies_resp_sink

// ### dv/testbench.sv
/* Self-checking bench for the event status block.
   Assumes the response sink model and the bound checker. */
`timescale 1ns/1ns
`include "ies_consts.vh"
module testbench;
    logic        i_clk = 0, i_nrst = 0, i_cmd_valid = 0, i_cmd_star = 0, slow = 0;
    logic        i_err_valid = 0, i_level_err = 0, i_ques_level = 0;
    logic [3:0]  i_cmd_code = 0;
    logic [15:0] i_cmd_arg = 0;
    logic [2:0]  i_err_class = 0, i_proc_idle = 3'h7;
    logic [7:0]  i_stb_ext = 8'h00, i_sre = 8'h20;
    wire         i_resp_ready, o_cls, o_resp_valid, o_resp_last;
    wire  [7:0]  o_event_enable_mask, o_standard_event_status, o_stb, o_resp_byte;
    integer      miscompares = 0, compares = 0, k, n;
    ies_event_status DUT (.i_clk, .i_nrst, .i_cmd_valid, .i_cmd_star, .i_cmd_code,
        .i_cmd_arg, .i_err_valid, .i_err_class, .i_level_err, .i_ques_level, .i_proc_idle,
        .i_stb_ext, .i_sre, .i_resp_ready, .o_event_enable_mask, .o_standard_event_status,
        .o_stb, .o_cls, .o_resp_valid,
        .o_resp_byte, .o_resp_last);
    ies_resp_sink sink (.i_clk, .i_valid(o_resp_valid), .i_byte(o_resp_byte),
        .i_last(o_resp_last), .i_slow(slow), .o_ready(i_resp_ready));
    initial forever #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (e !== g)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmd(input logic st, input logic [3:0] c, input logic [15:0] a);
        @(negedge i_clk);
        {i_cmd_valid, i_cmd_star, i_cmd_code, i_cmd_arg} = {1'b1, st, c, a};
        @(negedge i_clk);
        i_cmd_valid = 0;
    endtask
    task err(input logic [2:0] c);
        @(negedge i_clk);
        {i_err_valid, i_err_class} = {1'b1, c};
        @(negedge i_clk);
        i_err_valid = 0;
    endtask
    // Bounded wait, so a missing last byte shows as a length mismatch
    task qry(input logic [3:0] c, input string s);
        sink.q.delete();
        sink.done = 0;
        cmd(1, c, 0);
        for (n = 0; n < 300 && !sink.done; n++)
            @(negedge i_clk);
        chk("resp_len", s.len(), sink.q.size());
        for (n = 0; n < s.len() && n < sink.q.size(); n++)
            chk("resp_byte", s[n], sink.q[n]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        miscompares++;
        final_report;
    end
    initial
    begin
        repeat (6) @(negedge i_clk);
        i_nrst = 1;
        chk("mask", 8'h00, o_event_enable_mask);
        qry(`IES_CMD_MASK_Q, "0");
        cmd(1, `IES_CMD_MASK_SET, 16'd60);
        qry(`IES_CMD_MASK_Q, "60");
        cmd(1, `IES_CMD_MASK_SET, 16'd300);
        chk("mask", 8'h3C, o_event_enable_mask);
        qry(`IES_CMD_STATUS_Q, "16");
        qry(`IES_CMD_STATUS_Q, "0");
        cmd(0, `IES_CMD_MASK_SET, 0);
        repeat (2) @(negedge i_clk);
        chk("stb", 8'h60, o_stb & 8'h60);
        qry(`IES_CMD_STATUS_Q, "32");
        for (k = 1; k < 5; k++)
        begin
            err(k[2:0]);
            repeat (3) @(negedge i_clk);
            chk("status", 8'h40 >> k, o_standard_event_status);
            cmd(1, `IES_CMD_CLS, 0);
            chk("cls", 8'h01, {7'h00, o_cls});
            chk("status", 8'h00, o_standard_event_status);
            chk("mask", 8'h3C, o_event_enable_mask);
        end
        // A level error alone, without its questionable bit, sets nothing
        @(negedge i_clk);
        i_level_err = 1'b1;
        @(negedge i_clk);
        chk("status", 8'h00, o_standard_event_status);
        i_ques_level = 1'b1;
        @(negedge i_clk);
        {i_level_err, i_ques_level} = 2'b00;
        chk("status", 8'h08, o_standard_event_status);
        cmd(1, `IES_CMD_MASK_SET, 16'd255);
        chk("mask", 8'h3D, o_event_enable_mask);
        qry(`IES_CMD_STATUS_Q, "8");
        i_proc_idle = 3'h6;
        cmd(1, `IES_CMD_OPC, 0);
        qry(`IES_CMD_OPC_Q, "0");
        qry(`IES_CMD_MASK_Q, "61");
        chk("status", 8'h00, o_standard_event_status);
        i_proc_idle = 3'h7;
        repeat (3) @(negedge i_clk);
        chk("status", 8'h01, o_standard_event_status);
        qry(`IES_CMD_OPC_Q, "1");
        slow = 1;
        qry(`IES_CMD_IDN_Q, "MAKER,PSU0000 36-28 01/01/2000,000001,1.00");
        qry(`IES_CMD_OPT_Q, "LIMCAL,REMBUS,MEMLOC,LISTAP");
        // A query while an answer still drains is refused and flagged
        cmd(1, `IES_CMD_OPT_Q, 0);
        cmd(1, `IES_CMD_MASK_Q, 0);
        chk("status", 8'h05, o_standard_event_status);
        repeat (80) @(negedge i_clk);
        chk("resp_valid", 8'h00, {7'h00, o_resp_valid});
        final_report;
    end
endmodule // testbench
